// File: ac_divider.sv
// Divides the sampled AC frequency edges by a power of two.
`timescale 1ns/1ps
`include "rxmod_consts.svh"
module ac_divider #(
  parameter int DIV_BITS = `AC_DIV_BITS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Edge in, divided level out
  input wire logic ac_rise,
  output logic div_out
);
  logic [DIV_BITS-1:0] cnt_r;

  // Half period of the output spans half the divide ratio of input edges.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (ce && ac_rise) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign div_out = cnt_r[DIV_BITS-1];
endmodule

// File: edge_sync.sv
// Two-stage synchroniser with a rising-edge detector.
`timescale 1ns/1ps
module edge_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Signal
  input wire logic din,
  output logic level,
  output logic rise
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else if (ce) begin
      meta_r <= din;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise = sync_r & ~prev_r & ce;
endmodule

// File: mcu_model.sv
// Behavioural microcontroller that drives the modulation input.
`timescale 1ns/1ps
module mcu_model (
  // Clock
  input wire logic clk,
  // Modulation drive
  output logic mod_out
);
  // The pin has a pull-down, so an idle controller leaves it low.
  initial mod_out = 1'b0;
  // Sends n pulses, one rising edge every gap cycles.
  task automatic send(input int n, input int gap);
    repeat (n) begin
      @(posedge clk) mod_out <= 1'b1;
      @(posedge clk) mod_out <= 1'b0;
      repeat (gap - 2) @(posedge clk);
    end
  endtask
  // Holds a level, active high closes the switches.
  task automatic level(input logic v);
    @(posedge clk) mod_out <= v;
  endtask
endmodule

// File: rx_modulator_mode_control.sv
// Modulation routing, mode control, load sink, alert and buck timing for the receiver.
//
// Function
// RULE1: ac_frequency_out toggles at the AC input frequency divided by eight; the code holds it low and drives the divided signal onto ac_frequency_oe_n.
// RULE2: Alert command from the transmitter drives mcu_alert_n low.
// RULE3: mcu_alert_n stays released at power up, only alert commands pull it.
// RULE4: In microcontroller control, a high input closes both switches, low opens them.
// RULE5: Switch control comes from internal modulator or the microcontroller input.
// RULE6: Switches close only during modulation events, otherwise open.
// RULE7: Standalone mode lets the internal modulator send the regulation messages.
// RULE8: In bypass the microcontroller toggles its input to send all packets.
// RULE9: Activity on the microcontroller input decides the mode transitions.
// RULE10: Stalled microcontroller activity returns control to standalone mode.
// RULE11: Load sink is on while the buck is off and load is low.
// RULE12: Near full duty the buck gets a minimum off-time every eighth cycle.
// RULE13: Buck picks pulse-frequency or pulse-width mode from load automatically.
// RULE14: Buck is disabled when AC power input disappears.
// RULE15: Eight pulses with gaps under 25 ms enter bypass from standalone.
// RULE16: Fewer than eight pulses in a 250 ms window return to standalone.
// RULE17: Config pin below 250 mV keeps the internal modulator bypassed permanently.
// RULE18: The microcontroller input is synchronised and rising edges are detected.
`timescale 1ns/1ps
`include "rxmod_consts.svh"
module rx_modulator_mode_control
  import rxmod_pkg::*;
#(
  parameter int GAP_CYC = `GAP_MAX_CYC,
  parameter int WIN_CYC = `STALL_WIN_CYC,
  parameter int PULSES = `BYPASS_PULSES,
  parameter int BOOST_PER = `BOOST_PERIOD
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Microcontroller side
  input wire logic mcu_modulation_input,
  output logic mcu_alert_n,
  output logic mcu_alert_oe_n,
  // Configuration comparator, high when the pin reads below 250 mV
  input wire logic modulation_config_low,
  // Internal modulator and transmitter command decoder
  input wire logic internal_mod_data,
  input wire logic tx_alert_cmd,
  // AC detector
  input wire logic ac_clk_in,
  input wire logic ac_present,
  output logic ac_frequency_out,
  output logic ac_frequency_oe_n,
  // Modulation switches, high closes the switch to ground
  output logic modulation_switch_a,
  output logic modulation_switch_b,
  // Buck regulator control
  input wire logic uvlo_ok,
  input wire logic load_low,
  input wire logic duty_near_full,
  input wire logic buck_cycle_start,
  output logic buck_enable,
  output logic buck_force_off,
  output logic buck_pfm_mode,
  output logic load_sink_en,
  output logic internal_mod_active
);
  localparam int GAP_W = $clog2(GAP_CYC + 1);
  localparam int WIN_W = $clog2(WIN_CYC + 1);
  localparam int BST_W = $clog2(BOOST_PER);
  localparam int OFF_W = $clog2(`BOOST_OFF_CYC + 1);

  mod_mode_t mode_r, mode_nxt;
  logic mod_level;
  logic mod_rise;
  logic ac_rise;
  logic ac_div;
  logic [GAP_W-1:0] gap_r;
  logic [WIN_W-1:0] win_r;
  logic [`PULSE_CNT_W-1:0] run_r;
  logic [`PULSE_CNT_W-1:0] win_cnt_r;
  logic [BST_W-1:0] bst_cnt_r;
  logic [OFF_W-1:0] off_r;

  function automatic logic [`PULSE_CNT_W-1:0] sat_inc(input logic [`PULSE_CNT_W-1:0] v);
    sat_inc = (v == {`PULSE_CNT_W{1'b1}}) ? v : v + 1'b1;
  endfunction

  edge_sync u_mod_sync (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .din(mcu_modulation_input),
    .level(mod_level),
    .rise(mod_rise)
  ); // RULE18

  edge_sync u_ac_sync (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .din(ac_clk_in),
    .level(),
    .rise(ac_rise)
  );

  ac_divider u_div (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .ac_rise(ac_rise),
    .div_out(ac_div)
  ); // RULE1

  // Pulse run counting in standalone; a gap of 25 ms or more restarts the run.
  // The timer saturates one short of the limit, so a gap of exactly GAP_CYC cycles already fails.
  wire gap_expired = (gap_r >= GAP_W'(GAP_CYC - 1));
  wire run_full = (run_r >= `PULSE_CNT_W'(PULSES - 1)) && mod_rise && !gap_expired;
  wire win_end = (win_r == WIN_W'(WIN_CYC - 1));
  wire win_stall = win_end && (win_cnt_r < `PULSE_CNT_W'(PULSES));
  wire boost_slot = duty_near_full && buck_cycle_start && (bst_cnt_r == '0);

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_STANDALONE: begin
        if (modulation_config_low) begin
          mode_nxt = MODE_FIXED_BYPASS; // RULE17
        end else if (run_full) begin
          mode_nxt = MODE_BYPASS; // RULE15 RULE9
        end
      end
      MODE_BYPASS: begin
        if (modulation_config_low) begin
          mode_nxt = MODE_FIXED_BYPASS;
        end else if (win_stall) begin
          mode_nxt = MODE_STANDALONE; // RULE16 RULE10
        end
      end
      MODE_FIXED_BYPASS: begin
        mode_nxt = MODE_FIXED_BYPASS;
      end
      default: begin
        mode_nxt = MODE_STANDALONE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= MODE_STANDALONE;
    end else if (ce) begin
      mode_r <= mode_nxt;
    end
  end

  // Gap timer and run counter, active in standalone only.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_r <= '0;
      run_r <= '0;
    end else if (ce) begin
      if (mode_r != MODE_STANDALONE) begin
        gap_r <= '0;
        run_r <= '0;
      end else if (mod_rise) begin
        gap_r <= '0;
        run_r <= gap_expired ? `PULSE_CNT_W'(1) : sat_inc(run_r);
      end else if (!gap_expired) begin
        gap_r <= gap_r + 1'b1;
      end
    end
  end

  // Fixed 250 ms windows of pulse counting while in bypass.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      win_r <= '0;
      win_cnt_r <= '0;
    end else if (ce) begin
      if (mode_r != MODE_BYPASS || win_end) begin
        win_r <= '0;
        win_cnt_r <= '0;
      end else begin
        win_r <= win_r + 1'b1;
        if (mod_rise) begin
          win_cnt_r <= sat_inc(win_cnt_r);
        end
      end
    end
  end

  // Boost recharge: every eighth cycle near full duty gets a forced off-time.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bst_cnt_r <= '0;
      off_r <= '0;
    end else if (ce) begin
      if (buck_cycle_start) begin
        bst_cnt_r <= bst_cnt_r + 1'b1;
      end
      if (boost_slot) begin
        off_r <= OFF_W'(`BOOST_OFF_CYC); // RULE12
      end else if (off_r != '0) begin
        off_r <= off_r - 1'b1;
      end
    end
  end

  wire mcu_owns = (mode_r != MODE_STANDALONE); // RULE5
  wire switch_nxt = mcu_owns ? mod_level : internal_mod_data; // RULE4 RULE6 RULE8
  wire buck_en_nxt = ac_present && uvlo_ok; // RULE14

  // All top outputs are registered.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      modulation_switch_a <= 1'b0;
      modulation_switch_b <= 1'b0;
      mcu_alert_n <= 1'b0;
      mcu_alert_oe_n <= 1'b1;
      ac_frequency_out <= 1'b0;
      ac_frequency_oe_n <= 1'b1;
      buck_enable <= 1'b0;
      buck_force_off <= 1'b0;
      buck_pfm_mode <= 1'b1;
      load_sink_en <= 1'b0;
      internal_mod_active <= 1'b1;
    end else if (ce) begin
      modulation_switch_a <= switch_nxt;
      modulation_switch_b <= switch_nxt;
      mcu_alert_oe_n <= !tx_alert_cmd; // RULE2 RULE3
      ac_frequency_oe_n <= ac_div; // RULE1
      buck_enable <= buck_en_nxt;
      buck_force_off <= boost_slot || (off_r > OFF_W'(1)); // RULE12
      buck_pfm_mode <= load_low; // RULE13
      load_sink_en <= !buck_en_nxt && load_low; // RULE11
      internal_mod_active <= !mcu_owns; // RULE7
    end
  end

  // A register only reflects the inputs of the previous edge if that edge was enabled.
  AST_ALERT_ONLY_CMD: assert property (@(posedge clk) disable iff (!rst_b) // RULE3
    ($past(ce) && !mcu_alert_oe_n) |-> $past(tx_alert_cmd))
    else $error("alert asserted without command");
  AST_ALERT_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
    (ce && tx_alert_cmd) |=> (!ce || !mcu_alert_oe_n))
    else $error("alert command not reflected");
  AST_MCU_SWITCH: assert property (@(posedge clk) disable iff (!rst_b) // RULE4
    (ce && mcu_owns) |=> (!ce || modulation_switch_a == $past(mod_level)))
    else $error("switch does not follow mcu input");
  AST_SWITCH_PAIR: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    modulation_switch_a == modulation_switch_b)
    else $error("switches differ");
  AST_FIXED_BYPASS: assert property (@(posedge clk) disable iff (!rst_b) // RULE17
    (mode_r == MODE_FIXED_BYPASS) |=> (mode_r == MODE_FIXED_BYPASS))
    else $error("left fixed bypass");
  AST_ENTER_BYPASS: assert property (@(posedge clk) disable iff (!rst_b) // RULE15
    ($rose(mode_r == MODE_BYPASS)) |-> $past(mod_rise))
    else $error("bypass entered without pulse");
  AST_LEAVE_BYPASS: assert property (@(posedge clk) disable iff (!rst_b) // RULE16
    (mode_r == MODE_BYPASS && mode_nxt == MODE_STANDALONE && ce) |-> win_end)
    else $error("bypass left outside window end");
  AST_SINK: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
    ($past(ce) && load_sink_en) |-> !$past(buck_en_nxt))
    else $error("sink on with buck on");
  AST_BUCK_OFF: assert property (@(posedge clk) disable iff (!rst_b) // RULE14
    (ce && !ac_present) |=> (!ce || !buck_enable))
    else $error("buck on without ac");
  AST_BOOST: assert property (@(posedge clk) disable iff (!rst_b) // RULE12
    (ce && boost_slot) |=> (!ce || buck_force_off))
    else $error("no forced off-time");
endmodule

// File: rx_modulator_mode_control_tb.sv
// Self-checking bench for the receiver modulation control block.
`timescale 1ns/1ps
module rx_modulator_mode_control_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic mcu_in, cfg_low = 1'b0, imd = 1'b0, alert_cmd = 1'b0, ac_clk, ac_pres = 1'b0;
  logic uvlo = 1'b0, ld_low = 1'b0, duty_full = 1'b0, bcs = 1'b0, ac_run = 1'b0;
  logic ce = 1'b1;
  logic [1:0] ac_ph = 2'h0;
  logic alert_n, alert_oe_n, ac_frequency_out_out, ac_frequency_out_oe_n, sw_a, sw_b, b_en, b_off, pfm, sink, int_act;
  int errors = 0, checks_done = 0, n, i, fo_high = 0;
  logic fo_meas = 1'b0;
  logic [2:0] r;
  always #20 clk = ~clk;
  // A slow AC clock, one rising edge every four system cycles.
  always @(posedge clk) if (ac_run) ac_ph <= ac_ph + 2'h1;
  assign ac_clk = ac_ph[1];
  always @(posedge clk) if (fo_meas && b_off === 1'b1) fo_high <= fo_high + 1;
  mcu_model mcu (.clk(clk), .mod_out(mcu_in));
  rx_modulator_mode_control #(.GAP_CYC(20), .WIN_CYC(200)) DUT (
    .clk(clk), .rst_b(rst_b), .ce(ce), .mcu_modulation_input(mcu_in),
    .mcu_alert_n(alert_n), .mcu_alert_oe_n(alert_oe_n), .modulation_config_low(cfg_low),
    .internal_mod_data(imd), .tx_alert_cmd(alert_cmd), .ac_clk_in(ac_clk),
    .ac_present(ac_pres), .ac_frequency_out(ac_frequency_out_out), .ac_frequency_oe_n(ac_frequency_out_oe_n),
    .modulation_switch_a(sw_a), .modulation_switch_b(sw_b), .uvlo_ok(uvlo),
    .load_low(ld_low), .duty_near_full(duty_full), .buck_cycle_start(bcs),
    .buck_enable(b_en), .buck_force_off(b_off), .buck_pfm_mode(pfm),
    .load_sink_en(sink), .internal_mod_active(int_act));
  // Buck enable, load sink and light-load mode from the supply inputs.
  function automatic logic [2:0] buck_exp(input logic ac, input logic uv, input logic ll);
    return {ac & uv, ~(ac & uv) & ll, ll};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask
  // Counts cycles until the frequency output enable next changes.
  task automatic span(output int c);
    logic v;
    v = ac_frequency_out_oe_n;
    c = 0;
    while (ac_frequency_out_oe_n === v && c < 100) begin
      @(negedge clk);
      c++;
    end
  endtask
  task automatic summarize;
    if (errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    summarize();
  end
  initial begin
    n = $urandom(67);
    repeat (9) @(posedge clk);
    chk({alert_oe_n, ac_frequency_out_oe_n, sw_a, sw_b, int_act}, 8'h19);
    @(posedge clk) rst_b <= 1'b1;
    for (i = 0; i < 12; i++) begin
      @(posedge clk) {alert_cmd, imd} <= 2'($urandom);
      settle(1);
      chk({sw_a, sw_b}, {imd, imd});
      chk(alert_oe_n, {7'h0, ~alert_cmd});
    end
    // With the enable low the switches must hold their old state.
    @(posedge clk) ce <= 1'b0;
    imd <= ~imd;
    settle(3);
    chk({sw_a, sw_b}, {~imd, ~imd});
    @(posedge clk) ce <= 1'b1;
    settle(1);
    chk({sw_a, sw_b}, {imd, imd});
    @(posedge clk) alert_cmd <= 1'b1;
    settle(2);
    chk({alert_oe_n, alert_n}, 8'h0);
    @(posedge clk) alert_cmd <= 1'b0;
    settle(2);
    chk(alert_oe_n, 8'h1);
    for (i = 0; i < 20; i++) begin
      r = $urandom;
      @(posedge clk) {ac_pres, uvlo, ld_low} <= r;
      settle(2);
      chk({b_en, sink, pfm}, buck_exp(r[2], r[1], r[0]));
    end
    @(posedge clk) ac_run <= 1'b1;
    settle(40);
    span(n);
    span(n);
    chk(n[7:0], 8'h10);
    chk(ac_frequency_out_out, 8'h0);
    @(posedge clk) {ac_pres, uvlo, duty_full, fo_meas} <= 4'hf;
    for (i = 0; i < 16; i++) begin
      @(posedge clk) bcs <= 1'b1;
      @(posedge clk) bcs <= 1'b0;
      repeat (8) @(posedge clk);
    end
    settle(10);
    chk(fo_high[7:0], 8'h0c);
    mcu.send(8, 30);
    settle(6);
    chk(int_act, 8'h1);
    mcu.send(7, 10);
    settle(30);
    chk(int_act, 8'h1);
    mcu.send(8, 10);
    settle(6);
    chk(int_act, 8'h0);
    mcu.level(1'b1);
    @(posedge clk) imd <= 1'b0;
    settle(4);
    chk({sw_a, sw_b}, 8'h3);
    mcu.level(1'b0);
    @(posedge clk) imd <= 1'b1;
    settle(4);
    chk({sw_a, sw_b}, 8'h0);
    mcu.send(25, 10);
    settle(1);
    chk(int_act, 8'h0);
    settle(420);
    chk(int_act, 8'h1);
    chk({sw_a, sw_b}, 8'h3);
    @(posedge clk) cfg_low <= 1'b1;
    mcu.level(1'b1);
    @(posedge clk) imd <= 1'b0;
    settle(6);
    chk({int_act, sw_a, sw_b}, 8'h3);
    mcu.level(1'b0);
    settle(500);
    chk({int_act, sw_a, sw_b}, 8'h0);
    @(posedge clk) ac_pres <= 1'b0;
    settle(2);
    chk(b_en, 8'h0);
    summarize();
  end
endmodule

// File: rxmod_consts.svh
// Constants for the receiver modulation control block.
`ifndef RXMOD_CONSTS_SVH
`define RXMOD_CONSTS_SVH

`define CLK_PERIOD_NS 40
`define BYPASS_PULSES 8
`define GAP_MAX_MS 25
`define GAP_MAX_CYC ((`GAP_MAX_MS * 1000000) / `CLK_PERIOD_NS)
`define STALL_WIN_MS 250
`define STALL_WIN_CYC ((`STALL_WIN_MS * 1000000) / `CLK_PERIOD_NS)
`define AC_DIV_BITS 3
`define BOOST_PERIOD 8
`define BOOST_OFF_NS 240
`define BOOST_OFF_CYC ((`BOOST_OFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_CNT_W 4

`endif

// File: rxmod_pkg.sv
// Types shared by the receiver modulation control block.
package rxmod_pkg;
  typedef enum logic [1:0] {
    MODE_STANDALONE = 2'b00,
    MODE_BYPASS = 2'b01,
    MODE_FIXED_BYPASS = 2'b11
  } mod_mode_t;
endpackage
